// ---- rtl/mode_supervision_control.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mode_supervision_map.svh"

module mode_supervision_control #(
   parameter int unsigned CNT_W = 20,
   parameter int unsigned NORMAL_REQUEST_CYCLES =
      `NORMAL_REQUEST_TIMEOUT_MS * (`CORE_CLK_HZ / 1000),
   parameter int unsigned WATCHDOG_CYCLES =
      `WATCHDOG_TIMEOUT_MS * (`CORE_CLK_HZ / 1000)
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic test_select_pin_i,
   input wire logic bus_wake_i,
   input wire logic wake_input_i,
   input wire logic sys_reset_n_i,
   output logic sys_reset_o,
   output logic sys_reset_oe_n_o,
   output logic regulator_on_o,
   output logic regulator_limit_o,
   output logic bus_rx_enable_o,
   output logic power_stage_enable_o,
   output logic stop_wake_o,
   output logic [3:0] mux_select_o,
   output logic [1:0] current_select_o,
   output logic current_source_on_o,
   output mode_supervision_pkg::mode_t mode_o
);
   import mode_supervision_pkg::*;

   localparam int unsigned HOLD_CYCLES =
      `RESET_HOLD_US * (`CORE_CLK_HZ / 1000000);
   localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
   localparam logic [CNT_W-1:0] REQ_LAST = CNT_W'(NORMAL_REQUEST_CYCLES - 1);
   localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WATCHDOG_CYCLES - 1);

   mode_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [3:0] sys_control, next_sys_control;
   logic [1:0] wake_mask, next_wake_mask;
   logic [6:0] amux, next_amux;
   logic [5:0] reset_status, next_reset_status;
   logic wake_prev, next_wake_prev;
   logic primed, next_primed;
   logic stop_wake, next_stop_wake;
   logic [7:0] next_rdata;

   logic wake_edge, ext_reset, wd_on, wd_wrong, wd_expired, wd_fire;
   logic sleep_wake, any_reset, wr_sys, wr_mask, wr_amux, wr_wd, wr_rst;
   logic [5:0] status_set;

   // Event decode; reset line is only watched while not pulling it low
   always_comb begin
      wr_sys = reg_wr_i && (reg_addr_i == `ADDR_SYS_CONTROL);
      wr_mask = reg_wr_i && (reg_addr_i == `ADDR_WAKE_MASK);
      wr_amux = reg_wr_i && (reg_addr_i == `ADDR_ANALOG_MUX_CONTROL);
      wr_wd = reg_wr_i && (reg_addr_i == `ADDR_WATCHDOG_SERVICE);
      wr_rst = reg_wr_i && (reg_addr_i == `ADDR_RESET_STATUS);
      wake_edge = primed && (wake_input_i != wake_prev);
      ext_reset = !sys_reset_n_i && (state != mode_reset) &&
                  (state != mode_sleep);
      wd_on = (state == mode_normal) && sys_control[`SYS_WATCHDOG_ENABLE_BIT];
      wd_wrong = wd_on && wr_wd &&
                 (reg_wdata_i != `WATCHDOG_RESTART_KEY);
      wd_expired = wd_on && (cnt == WD_LAST) && !wr_wd;
      wd_fire = wd_wrong || wd_expired;
      sleep_wake = (state == mode_sleep) && (bus_wake_i || wake_edge);
      any_reset = ext_reset || wd_fire || sleep_wake;
   end

   // Mode, counter and register next values
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sys_control = sys_control;
      next_wake_mask = wake_mask;
      next_amux = amux;
      next_stop_wake = 1'b0;
      next_wake_prev = wake_input_i;
      next_primed = 1'b1;
      status_set = 6'h00;
      if (wr_sys) begin
         next_sys_control = reg_wdata_i[3:0];
      end
      if (wr_mask) begin
         next_wake_mask = reg_wdata_i[1:0];
      end
      if (wr_amux) begin
         // Out-of-range sources are dropped so the mux never floats
         if (reg_wdata_i[3:0] < `AMUX_SOURCE_COUNT) begin
            next_amux[3:0] = reg_wdata_i[3:0];
         end
         next_amux[6:4] = reg_wdata_i[6:4];
      end
      unique case (state)
         mode_reset: begin
            next_cnt = cnt + CNT_W'(1);
            if (cnt == HOLD_LAST) begin
               next_state = mode_start_wait;
               next_cnt = '0;
            end
         end
         mode_start_wait: begin
            if (sys_control[`SYS_POWER_STAGE_ON_BIT]) begin
               next_state = mode_normal;
               next_cnt = '0;
            end else if (!test_select_pin_i) begin
               if (cnt == REQ_LAST) begin
                  next_state = mode_sleep;
                  status_set[`RST_TIMEOUT_BIT] = 1'b1;
                  next_cnt = '0;
               end else begin
                  next_cnt = cnt + CNT_W'(1);
               end
            end
         end
         mode_normal: begin
            // Correct key restarts the watchdog window
            if (wr_wd || !sys_control[`SYS_WATCHDOG_ENABLE_BIT]) begin
               next_cnt = '0;
            end else begin
               next_cnt = cnt + CNT_W'(1);
            end
            if (sys_control[`SYS_SLEEP_BIT]) begin
               next_state = mode_sleep;
            end else if (sys_control[`SYS_STOP_BIT]) begin
               next_state = mode_stop;
            end
         end
         mode_stop: begin
            if ((bus_wake_i && wake_mask[`MASK_BUS_WAKE_ENABLE_BIT]) ||
                (wake_edge && wake_mask[`MASK_WAKE_INPUT_ENABLE_BIT])) begin
               next_state = mode_normal;
               next_sys_control[`SYS_STOP_BIT] = 1'b0;
               next_stop_wake = 1'b1;
               next_cnt = '0;
            end
         end
         mode_sleep: begin
            next_cnt = '0;
         end
      endcase
      // Any reset source clears all but the reset status
      if (any_reset) begin
         next_state = mode_reset;
         next_cnt = '0;
         next_sys_control = `SYS_CONTROL_RESET;
         next_wake_mask = `WAKE_MASK_RESET;
         next_amux = `ANALOG_MUX_CONTROL_RESET;
         next_stop_wake = 1'b0;
      end
      status_set[`RST_EXTERNAL_BIT] = ext_reset;
      status_set[`RST_WATCHDOG_BIT] = wd_fire;
      status_set[`RST_WAKE_INPUT_BIT] = sleep_wake && wake_edge;
      status_set[`RST_BUS_WAKE_BIT] = sleep_wake && bus_wake_i;
      // Set wins over a write-one clear in the same cycle
      next_reset_status = reset_status;
      if (wr_rst) begin
         next_reset_status = reset_status & ~reg_wdata_i[5:0];
      end
      next_reset_status = next_reset_status | status_set;
   end

   // State and register flops
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state <= mode_reset;
         cnt <= '0;
         sys_control <= `SYS_CONTROL_RESET;
         wake_mask <= `WAKE_MASK_RESET;
         amux <= `ANALOG_MUX_CONTROL_RESET;
         reset_status <= `RESET_STATUS_RESET;
         wake_prev <= 1'b0;
         primed <= 1'b0;
         stop_wake <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sys_control <= next_sys_control;
         wake_mask <= next_wake_mask;
         amux <= next_amux;
         reset_status <= next_reset_status;
         wake_prev <= next_wake_prev;
         primed <= next_primed;
         stop_wake <= next_stop_wake;
      end
   end

   // Read data, valid only in the cycle after the read strobe
   always_comb begin
      next_rdata = 8'h00;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `ADDR_SYS_CONTROL: next_rdata = {4'h0, sys_control};
            `ADDR_WAKE_MASK: next_rdata = {6'h00, wake_mask};
            `ADDR_ANALOG_MUX_CONTROL: next_rdata = {1'b0, amux};
            `ADDR_RESET_STATUS: next_rdata = {2'h0, reset_status};
            `ADDR_MODE_STATUS: next_rdata = {3'h0, state};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= next_rdata;
      end
   end

   // Pin and mode outputs, decoded from flops and the test select pin
   always_comb begin
      mode_o = state;
      sys_reset_o = 1'b0;
      sys_reset_oe_n_o = (state != mode_reset) && (state != mode_sleep);
      regulator_on_o = (state != mode_sleep);
      regulator_limit_o = (state == mode_stop);
      bus_rx_enable_o = (state == mode_normal) && !test_select_pin_i;
      power_stage_enable_o = (state == mode_normal) &&
                             sys_control[`SYS_POWER_STAGE_ON_BIT];
      stop_wake_o = stop_wake;
      mux_select_o = amux[3:0];
      current_select_o = amux[5:4];
      current_source_on_o = amux[`AMUX_CURRENT_ON_BIT];
   end

   // Checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);

   property p_sleep_select;
      (state == mode_normal) && sys_control[`SYS_SLEEP_BIT] && !any_reset
      |=> (state == mode_sleep);
   endproperty
   a_sleep_select: assert property (p_sleep_select)
      else $error("sleep bit did not select sleep");

   property p_timeout_sleep;
      (state == mode_start_wait) && !sys_control[`SYS_POWER_STAGE_ON_BIT] &&
      !test_select_pin_i && (cnt == REQ_LAST) && !any_reset
      |=> (state == mode_sleep) && reset_status[`RST_TIMEOUT_BIT];
   endproperty
   a_timeout_sleep: assert property (p_timeout_sleep)
      else $error("supervision timeout did not enter sleep");

   property p_hold_release;
      (state == mode_reset) && (cnt == HOLD_LAST) && !any_reset
      |=> (state == mode_start_wait) && (cnt == '0);
   endproperty
   a_hold_release: assert property (p_hold_release)
      else $error("reset hold did not start supervision");

   property p_test_freeze;
      (state == mode_start_wait) && test_select_pin_i &&
      !sys_control[`SYS_POWER_STAGE_ON_BIT] && !any_reset
      |=> (state == mode_start_wait) && $stable(cnt) && !bus_rx_enable_o;
   endproperty
   a_test_freeze: assert property (p_test_freeze)
      else $error("test mode did not suppress supervision");

   property p_wd_reset;
      wd_fire |=> (state == mode_reset) && reset_status[`RST_WATCHDOG_BIT]
                  ##HOLD_CYCLES (state == mode_start_wait);
   endproperty
   a_wd_reset: assert property (p_wd_reset)
      else $error("watchdog event did not reset");

   property p_wd_scope;
      wd_fire |=> (sys_control == `SYS_CONTROL_RESET) &&
                  (amux == `ANALOG_MUX_CONTROL_RESET) &&
                  (wake_mask == `WAKE_MASK_RESET) &&
                  ((reset_status & ~$past(status_set)) == $past(reset_status &
                   ~status_set & ~({6{wr_rst}} & reg_wdata_i[5:0])));
   endproperty
   a_wd_scope: assert property (p_wd_scope)
      else $error("watchdog reset scope wrong");

   property p_mux_select;
      wr_amux && (reg_wdata_i[3:0] < `AMUX_SOURCE_COUNT) && !any_reset
      |=> (mux_select_o == $past(reg_wdata_i[3:0])) &&
          (current_select_o == $past(reg_wdata_i[5:4]));
   endproperty
   a_mux_select: assert property (p_mux_select)
      else $error("analog select not applied");

   property p_stop_supply;
      (state == mode_stop) |-> regulator_on_o && regulator_limit_o &&
                               sys_reset_oe_n_o;
   endproperty
   a_stop_supply: assert property (p_stop_supply)
      else $error("stop supply wrong");

   property p_sleep_wake;
      (state == mode_sleep) && bus_wake_i |-> !regulator_on_o &&
      !sys_reset_oe_n_o ##1 (state == mode_reset) &&
      reset_status[`RST_BUS_WAKE_BIT];
   endproperty
   a_sleep_wake: assert property (p_sleep_wake)
      else $error("sleep wake not a power-on reset");

   property p_stop_mask;
      (state == mode_stop) && !ext_reset &&
      !(wake_mask[`MASK_BUS_WAKE_ENABLE_BIT] && bus_wake_i) &&
      !(wake_mask[`MASK_WAKE_INPUT_ENABLE_BIT] && wake_edge)
      |=> (state == mode_stop);
   endproperty
   a_stop_mask: assert property (p_stop_mask)
      else $error("masked wake left stop");

   c_normal: cover property ((state == mode_start_wait) ##1
                             (state == mode_normal));
   c_stop_wake: cover property ((state == mode_stop) ##1 stop_wake_o);
   c_timeout: cover property ((state == mode_start_wait) ##1
                              (state == mode_sleep));
   c_wd: cover property (wd_wrong);

endmodule : mode_supervision_control

`default_nettype wire

// ---- rtl/mode_supervision_map.svh ----
`ifndef MODE_SUPERVISION_MAP_SVH
`define MODE_SUPERVISION_MAP_SVH

// Clock rate of the core clock
`define CORE_CLK_HZ 10000000

// Register indices on the plain register port
`define ADDR_SYS_CONTROL 3'h0
`define ADDR_WAKE_MASK 3'h1
`define ADDR_ANALOG_MUX_CONTROL 3'h2
`define ADDR_WATCHDOG_SERVICE 3'h3
`define ADDR_RESET_STATUS 3'h4
`define ADDR_MODE_STATUS 3'h5

// System control fields
`define SYS_POWER_STAGE_ON_BIT 0
`define SYS_STOP_BIT 1
`define SYS_SLEEP_BIT 2
`define SYS_WATCHDOG_ENABLE_BIT 3
`define SYS_CONTROL_RESET 4'h0

// Wake mask fields
`define MASK_BUS_WAKE_ENABLE_BIT 0
`define MASK_WAKE_INPUT_ENABLE_BIT 1
`define WAKE_MASK_RESET 2'h0

// Analog mux control fields
`define AMUX_SOURCE_LSB 0
`define AMUX_CURRENT_LSB 4
`define AMUX_CURRENT_ON_BIT 6
`define AMUX_SOURCE_COUNT 4'hB
`define ANALOG_MUX_CONTROL_RESET 7'h00

// Reset status flags
`define RST_POWER_ON_BIT 0
`define RST_EXTERNAL_BIT 1
`define RST_WATCHDOG_BIT 2
`define RST_WAKE_INPUT_BIT 3
`define RST_BUS_WAKE_BIT 4
`define RST_TIMEOUT_BIT 5
`define RESET_STATUS_RESET 6'h01

// Watchdog restart key
`define WATCHDOG_RESTART_KEY 8'hA5

// Timing: figures in their own units
`define NORMAL_REQUEST_TIMEOUT_MS 80
`define WATCHDOG_TIMEOUT_MS 50
`define RESET_HOLD_US 10

`endif

// ---- rtl/mode_supervision_pkg.sv ----
package mode_supervision_pkg;

   // Operating mode, one-hot
   typedef enum logic [4:0] {
      mode_reset = 5'h01,
      mode_start_wait = 5'h02,
      mode_normal = 5'h04,
      mode_stop = 5'h08,
      mode_sleep = 5'h10
   } mode_t;

endpackage : mode_supervision_pkg

// ---- test/mcu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mode_supervision_map.svh"

// Register master standing in for the embedded controller
module mcu_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic [2:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   // Idle bus at time zero
   initial begin
      addr_o = 3'h0;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // One-cycle write strobe, changed just after the edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d; // Stale data would hide a late sample
   endtask : wr

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1;
      d = rdata_i;
   endtask : rd

   // Software proves it is alive after a reset
   task automatic confirm();
      wr(`ADDR_SYS_CONTROL, 8'h01);
   endtask : confirm

   // Stop request; the halt itself is outside this model
   task automatic enter_stop();
      wr(`ADDR_SYS_CONTROL, 8'h03);
   endtask : enter_stop
endmodule : mcu_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mode_supervision_map.svh"

module tb;
   import mode_supervision_pkg::*;
   localparam int unsigned T_REQ = 200;
   localparam int unsigned T_WD = 300;
   localparam int PIN_BUS = 0, PIN_WAKE = 1, PIN_EXT = 2;
   logic core_clk_i, reset_i, test_select_pin_i, bus_wake_i;
   logic wake_input_i, ext_low, sys_line, sys_reset_o, sys_reset_oe_n_o;
   logic regulator_on_o, regulator_limit_o, bus_rx_enable_o, stop_wake_o;
   logic power_stage_enable_o, current_source_on_o, reg_wr_i, reg_rd_i;
   logic [2:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, d;
   logic [3:0] mux_select_o;
   logic [1:0] current_select_o;
   mode_t mode_o;
   int n_fail = 0;
   int n_compared = 0;

   // Open-drain reset line with pull-up
   assign sys_line = !sys_reset_oe_n_o ? sys_reset_o : !ext_low;

   mode_supervision_control #(.NORMAL_REQUEST_CYCLES(T_REQ),
      .WATCHDOG_CYCLES(T_WD)) i_mode_supervision_control (
      .core_clk_i(core_clk_i), .reset_i(reset_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .test_select_pin_i(test_select_pin_i), .bus_wake_i(bus_wake_i),
      .wake_input_i(wake_input_i), .sys_reset_n_i(sys_line),
      .sys_reset_o(sys_reset_o), .sys_reset_oe_n_o(sys_reset_oe_n_o),
      .regulator_on_o(regulator_on_o),
      .regulator_limit_o(regulator_limit_o),
      .bus_rx_enable_o(bus_rx_enable_o),
      .power_stage_enable_o(power_stage_enable_o),
      .stop_wake_o(stop_wake_o), .mux_select_o(mux_select_o),
      .current_select_o(current_select_o),
      .current_source_on_o(current_source_on_o), .mode_o(mode_o));

   mcu_model u_mcu (.clk_i(core_clk_i), .rdata_i(reg_rdata_o),
      .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i),
      .rd_o(reg_rd_i));

   // 10 MHz core clock
   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   task automatic end_of_test();
      if (n_fail == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test

   task automatic check(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   // Bounded wait; first look is off the edge so a fresh change is seen
   task automatic wait_mode(input mode_t m, input int lim);
      #1;
      for (int i = 0; i < lim && mode_o !== m; i++) begin
         @(posedge core_clk_i);
         #1;
      end
      check("mode", {3'h0, m}, {3'h0, mode_o});
   endtask : wait_mode

   // One pin high for n cycles: bus wake, wake input or line pull-down
   task automatic pulse(input int which, input int n);
      for (int k = 0; k < 2; k++) begin
         if (k == 0) @(posedge core_clk_i);
         else repeat (n) @(posedge core_clk_i);
         case (which)
            PIN_BUS: bus_wake_i <= (k == 0);
            PIN_WAKE: wake_input_i <= (k == 0);
            default: ext_low <= (k == 0);
         endcase
      end
   endtask : pulse

   task automatic power_up();
      @(posedge core_clk_i);
      reset_i <= 1'b1;
      repeat (16) @(posedge core_clk_i);
      reset_i <= 1'b0;
      wait_mode(mode_reset, 1);
   endtask : power_up

   task automatic go_normal();
      wait_mode(mode_start_wait, 110);
      u_mcu.confirm();
      wait_mode(mode_normal, 3);
   endtask : go_normal

   task automatic t_start();
      power_up();
      go_normal();
      check("stage", 8'h01, power_stage_enable_o);
      check("bus_rx", 8'h01, bus_rx_enable_o);
      u_mcu.rd(`ADDR_MODE_STATUS, d);
      check("mode_reg", 8'h04, d);
   endtask : t_start

   task automatic t_mux();
      u_mcu.wr(`ADDR_ANALOG_MUX_CONTROL, 8'h7A);
      #1;
      check("mux", 8'h0A, mux_select_o);
      check("cur", 8'h07, {current_source_on_o, current_select_o});
      u_mcu.wr(`ADDR_ANALOG_MUX_CONTROL, 8'h1B);
      #1;
      check("mux", 8'h0A, mux_select_o);
      check("cur", 8'h01, {current_source_on_o, current_select_o});
   endtask : t_mux

   task automatic t_stop();
      u_mcu.wr(`ADDR_WAKE_MASK, 8'h00);
      u_mcu.enter_stop();
      wait_mode(mode_stop, 3);
      check("limit", 8'h03, {regulator_on_o, regulator_limit_o});
      pulse(PIN_BUS, 3);
      pulse(PIN_WAKE, 3);
      repeat (3) @(posedge core_clk_i);
      wait_mode(mode_stop, 1);
      u_mcu.wr(`ADDR_WAKE_MASK, 8'h02);
      pulse(PIN_BUS, 2);
      wait_mode(mode_stop, 2);
      pulse(PIN_WAKE, 1);
      wait_mode(mode_normal, 4);
      check("stop_wake", 8'h01, stop_wake_o);
      u_mcu.wr(`ADDR_WAKE_MASK, 8'h01);
      u_mcu.enter_stop();
      wait_mode(mode_stop, 3);
      pulse(PIN_BUS, 1);
      wait_mode(mode_normal, 4);
   endtask : t_stop

   task automatic t_watchdog();
      u_mcu.wr(`ADDR_RESET_STATUS, 8'h3F);
      u_mcu.wr(`ADDR_SYS_CONTROL, 8'h09);
      u_mcu.wr(`ADDR_ANALOG_MUX_CONTROL, 8'h05);
      u_mcu.wr(`ADDR_WATCHDOG_SERVICE, `WATCHDOG_RESTART_KEY);
      wait_mode(mode_normal, 1);
      u_mcu.wr(`ADDR_WATCHDOG_SERVICE, 8'h00);
      wait_mode(mode_reset, 3);
      check("mux", 8'h00, mux_select_o);
      u_mcu.rd(`ADDR_RESET_STATUS, d);
      check("status", 8'h04, d);
      go_normal();
      u_mcu.wr(`ADDR_SYS_CONTROL, 8'h09);
      repeat (T_WD - 20) @(posedge core_clk_i);
      wait_mode(mode_normal, 1);
      wait_mode(mode_reset, 40);
   endtask : t_watchdog

   task automatic t_ext();
      go_normal();
      pulse(PIN_EXT, 2);
      wait_mode(mode_reset, 4);
      check("line", 8'h00, {sys_reset_o, sys_reset_oe_n_o});
      u_mcu.rd(`ADDR_RESET_STATUS, d);
      check("ext_flag", 8'h02, d & 8'h02);
      go_normal();
   endtask : t_ext

   task automatic t_test();
      @(posedge core_clk_i);
      test_select_pin_i <= 1'b1;
      power_up();
      repeat (T_REQ + 150) @(posedge core_clk_i);
      wait_mode(mode_start_wait, 1);
      u_mcu.confirm();
      wait_mode(mode_normal, 3);
      check("bus_rx", 8'h00, bus_rx_enable_o);
      @(posedge core_clk_i);
      test_select_pin_i <= 1'b0;
   endtask : t_test

   task automatic t_timeout();
      power_up();
      wait_mode(mode_start_wait, 110);
      repeat (T_REQ - 20) @(posedge core_clk_i);
      wait_mode(mode_start_wait, 1);
      wait_mode(mode_sleep, 30);
      check("sleep_out", 8'h00, {regulator_on_o, sys_reset_oe_n_o});
      pulse(PIN_BUS, 1);
      wait_mode(mode_reset, 4);
      u_mcu.rd(`ADDR_RESET_STATUS, d);
      check("status", 8'h30, d & 8'h30);
   endtask : t_timeout

   // Sleep chosen by software, left again through the wake input
   task automatic t_sleep();
      go_normal();
      u_mcu.wr(`ADDR_SYS_CONTROL, 8'h05);
      wait_mode(mode_sleep, 3);
      check("sleep_out", 8'h00, {regulator_on_o, sys_reset_oe_n_o});
      pulse(PIN_WAKE, 1);
      wait_mode(mode_reset, 4);
      u_mcu.rd(`ADDR_RESET_STATUS, d);
      check("wake_flag", 8'h08, d & 8'h08);
   endtask : t_sleep

   // Hang guard, well beyond the roughly 1600 cycles of the run
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_fail++;
      end_of_test();
   end

   initial begin
      reset_i = 1'b1;
      test_select_pin_i = 1'b0;
      bus_wake_i = 1'b0;
      wake_input_i = 1'b0;
      ext_low = 1'b0;
      t_start();
      t_mux();
      t_stop();
      t_watchdog();
      t_ext();
      t_test();
      t_timeout();
      t_sleep();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
